// ===== design/pdsl_core.sv
/*
  Digital core of an integer-N synthesizer: three-wire serial load port,
  reference divider, 32/33 prescaler with swallow and programmable counters,
  phase/frequency detector and charge-pump drive.
  Assumes all pins arrive asynchronous to sys_clk (20 MHz); all but chip_enable and rst are sampled;
  the oscillator and RF inputs must therefore toggle well below sys_clk/4.
*/
`timescale 1ns/1ps
module pdsl_core (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Serial programming pins
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic load_strobe,
  // Power control pin
  input  wire logic chip_enable,
  // Frequency inputs
  input  wire logic osc_in,
  input  wire logic rf_input,
  input  wire logic rf_input_complement,
  // Charge pump: level drives high (source) or low (sink)
  output logic      pump_output,
  output logic      pump_output_oe,
  // Divided signals for observation
  output logic      ref_div_out,
  output logic      fb_div_out
);

  localparam int DW = pdsl_pkg::DATA_W;
  localparam int RW = pdsl_pkg::R_CNT_W;
  localparam int AW = pdsl_pkg::A_W;
  localparam int BW = pdsl_pkg::B_W;
  localparam int PW = pdsl_pkg::PRESC_W;

  // Synchronised pin levels
  logic [4:0] pin_lvl;
  logic       sclk_lvl;
  logic       sdat_lvl;
  logic       strb_lvl;
  logic       osc_lvl;
  logic       rf_lvl;

  // Differential RF pair seen as one level; single-ended grounds the minus
  pdsl_sync #(
    .WIDTH     (5)
  ) u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pin_in    ({ser_clk, ser_data, load_strobe, osc_in,
                 rf_input & ~rf_input_complement}),
    .level_out (pin_lvl)
  );

  assign {sclk_lvl, sdat_lvl, strb_lvl, osc_lvl, rf_lvl} = pin_lvl;

  // Previous levels for edge detection
  logic sclk_prev_r;
  logic strb_prev_r;
  logic osc_prev_r;
  logic rf_prev_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_r <= 1'b0;
      strb_prev_r <= 1'b0;
      osc_prev_r  <= 1'b0;
      rf_prev_r   <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_lvl;
      strb_prev_r <= strb_lvl;
      osc_prev_r  <= osc_lvl;
      rf_prev_r   <= rf_lvl;
    end
  end

  logic sclk_rise;
  logic strb_rise;
  logic osc_rise;
  logic rf_rise;

  assign sclk_rise = sclk_lvl & ~sclk_prev_r;
  assign strb_rise = strb_lvl & ~strb_prev_r;
  assign osc_rise  = osc_lvl & ~osc_prev_r;
  assign rf_rise   = rf_lvl & ~rf_prev_r;

  // Serial shift register; only rst clears it, never a power-down
  logic [pdsl_pkg::SHIFT_W-1:0] shift_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[pdsl_pkg::SHIFT_W-2:0], sdat_lvl};
    end
  end

  // Two latches loaded on the strobe edge
  logic [DW-1:0] ref_latch_r;
  logic [DW-1:0] fb_latch_r;
  logic [DW-1:0] word_data;

  assign word_data = shift_r[pdsl_pkg::SHIFT_W-1:1];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_latch_r <= pdsl_pkg::REF_RST;
      fb_latch_r  <= pdsl_pkg::FB_RST;
    end else if (strb_rise) begin
      if (shift_r[pdsl_pkg::ADDR_POS] == pdsl_pkg::ADDR_REF) begin
        ref_latch_r <= word_data;
      end else begin
        fb_latch_r <= word_data;
      end
    end
  end

  // Latch fields
  logic          cp_tri;
  logic          pd_pol;
  logic          test_mode;
  logic          soft_power_down;
  logic [RW-1:0] r_ratio;
  logic [AW-1:0] a_val;
  logic [BW-1:0] b_val;

  // Prohibited small ratios are raised to the legal minimum
  assign r_ratio = (ref_latch_r[pdsl_pkg::R_CNT_LSB +: RW] < pdsl_pkg::R_MIN)
                 ? pdsl_pkg::R_MIN
                 : ref_latch_r[pdsl_pkg::R_CNT_LSB +: RW];
  assign b_val   = (fb_latch_r[pdsl_pkg::B_LSB +: BW] < pdsl_pkg::B_MIN)
                 ? pdsl_pkg::B_MIN
                 : fb_latch_r[pdsl_pkg::B_LSB +: BW];
  // Swallow count capped at B so the ratio stays 32*B+A
  assign a_val   = ({5'h00, fb_latch_r[pdsl_pkg::A_LSB +: AW]} > b_val)
                 ? b_val[AW-1:0]
                 : fb_latch_r[pdsl_pkg::A_LSB +: AW];
  assign cp_tri          = ref_latch_r[pdsl_pkg::CP_TRI_BIT];
  assign pd_pol          = ref_latch_r[pdsl_pkg::PD_POL_BIT];
  assign test_mode       = ref_latch_r[pdsl_pkg::TEST_BIT];
  assign soft_power_down = fb_latch_r[pdsl_pkg::SOFT_POWER_DOWN_BIT];

  // Chip enable low clears the whole loop without a clock edge.
  // Derived async clear: glitches on the pin act immediately by design.
  logic hard_clr;

  assign hard_clr = rst | ~chip_enable;

  // Reference counter on oscillator edges
  logic [RW-1:0] r_cnt_r;
  logic          ref_tick;

  assign ref_tick = osc_rise & (r_cnt_r == '0);

  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      r_cnt_r <= '0;
    end else if (soft_power_down) begin
      r_cnt_r <= '0; // Counters reset so both restart aligned
    end else if (osc_rise) begin
      if (r_cnt_r == '0) begin
        r_cnt_r <= r_ratio - 10'h001;
      end else begin
        r_cnt_r <= r_cnt_r - 10'h001;
      end
    end
  end

  // Prescaler: modulus 33 while swallow count remains, else 32
  logic [PW-1:0] presc_r;
  logic [AW-1:0] a_left_r;
  logic [BW-1:0] b_left_r;
  logic [PW-1:0] presc_mod;
  logic          presc_wrap;
  logic          fb_tick;

  assign presc_mod  = (a_left_r != '0) ? pdsl_pkg::PRESC_HI
                                       : pdsl_pkg::PRESC_LO;
  assign presc_wrap = rf_rise & (presc_r == presc_mod - 6'h01);
  assign fb_tick    = presc_wrap & (b_left_r <= 10'h001);

  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      presc_r <= '0;
    end else if (soft_power_down) begin
      presc_r <= '0;
    end else if (rf_rise) begin
      presc_r <= presc_wrap ? '0 : presc_r + 6'h01;
    end
  end

  // Swallow and programmable counters step on each prescaler wrap;
  // ratio = 33*A + 32*(B-A) = 32*B + A, at most 32767
  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      a_left_r <= '0;
      b_left_r <= '0;
    end else if (soft_power_down) begin
      a_left_r <= '0;
      b_left_r <= '0;
    end else if (presc_wrap) begin
      if (fb_tick) begin
        a_left_r <= a_val;
        b_left_r <= b_val;
      end else begin
        b_left_r <= b_left_r - 10'h001;
        if (a_left_r != '0) begin
          a_left_r <= a_left_r - 5'h01;
        end
      end
    end
  end

  // Divided outputs as half-rate square waves
  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      ref_div_out <= 1'b0;
      fb_div_out  <= 1'b0;
    end else begin
      if (ref_tick) begin
        ref_div_out <= ~ref_div_out;
      end
      if (fb_tick) begin
        fb_div_out <= ~fb_div_out;
      end
    end
  end

  // Phase/frequency detector: two flags, cleared when both are set
  logic up_r;
  logic dn_r;
  logic up_nxt;
  logic dn_nxt;

  always_comb begin
    up_nxt = up_r | ref_tick;
    dn_nxt = dn_r | fb_tick;
    if (up_nxt & dn_nxt) begin
      up_nxt = 1'b0;
      dn_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else if (soft_power_down | cp_tri) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  // Pump drive; polarity swaps source and sink for negative VCOs
  logic pump_nxt;
  logic pump_oe_nxt;

  always_comb begin
    if (test_mode) begin
      pump_nxt    = pd_pol ? fb_div_out : ref_div_out;
      pump_oe_nxt = ~soft_power_down;
    end else begin
      pump_nxt    = pd_pol ? up_nxt : dn_nxt;
      pump_oe_nxt = (up_nxt ^ dn_nxt) & ~cp_tri & ~soft_power_down;
    end
  end

  // Registered pump pins; floated at once when chip enable drops
  always_ff @(posedge sys_clk or posedge hard_clr) begin
    if (hard_clr) begin
      pump_output    <= 1'b0;
      pump_output_oe <= 1'b0;
    end else begin
      pump_output    <= pump_nxt;
      pump_output_oe <= pump_oe_nxt;
    end
  end

endmodule

// ===== design/pdsl_pkg.sv
/*
  Constants for the divider core of the integer-N synthesizer: serial word
  layout, field positions inside the two latches, prescaler moduli, limits.
  Assumes nothing of its surroundings; used by the core only, not by its synchroniser.
*/
package pdsl_pkg;

  // Serial word: data field above one address bit
  localparam int SHIFT_W  = 18;
  localparam int DATA_W   = 17;
  localparam int ADDR_POS = 0;
  localparam logic ADDR_REF = 1'b1;

  // Reference latch fields (data-field bit numbers)
  localparam int R_CNT_LSB  = 0;
  localparam int R_CNT_W    = 10;
  localparam int CP_TRI_BIT = 10;
  localparam int PD_POL_BIT = 11;
  localparam int TEST_BIT   = 13;

  // Feedback latch fields (data-field bit numbers)
  localparam int SOFT_POWER_DOWN_BIT = 1;
  localparam int A_LSB    = 2;
  localparam int A_W      = 5;
  localparam int B_LSB    = 7;
  localparam int B_W      = 10;

  // Dual-modulus prescaler
  localparam int PRESC_W = 6;
  localparam logic [PRESC_W-1:0] PRESC_LO = 6'h20;
  localparam logic [PRESC_W-1:0] PRESC_HI = 6'h21;

  // Smallest legal divide ratios
  localparam logic [R_CNT_W-1:0] R_MIN = 10'h002;
  localparam logic [B_W-1:0]     B_MIN = 10'h003;

  // Latch reset values: pump three-stated, counters at legal minimum
  localparam logic [DATA_W-1:0] REF_RST = 17'h00402;
  localparam logic [DATA_W-1:0] FB_RST  = 17'h00180;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage

// ===== design/pdsl_sync.sv
/*
  Three-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to sys_clk; the output follows only
  when the second and third stages agree.
*/
`timescale 1ns/1ps
module pdsl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Pin side
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered side
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // Stage one is read by stage two only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Accept a bit only once two stages agree, to reject a lone glitch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_out[i] <= stage2_r[i];
        end
      end
    end
  end

endmodule

// ===== tb/pdsl_core_properties.sv
/* Pin-level assertions for the divider core: power down, ratio limits
   and the cause of pump drive. Assumes pins change after sys_clk rises. */
`timescale 1ns/1ps
module pdsl_core_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Inputs watched
  input wire logic chip_enable,
  input wire logic osc_in,
  input wire logic rf_input,
  input wire logic rf_input_complement,
  // Outputs watched
  input wire logic pump_output_oe,
  input wire logic ref_div_out,
  input wire logic fb_div_out
);
  logic [15:0] osc_cnt_r;
  logic [15:0] rf_cnt_r;
  logic        ref_seen_r;
  logic        fb_seen_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Edges since the last toggle; cleared while chip_enable is low, but not by soft power down as the counters are
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      osc_cnt_r <= 16'h0000;
    else if (!chip_enable || $changed(ref_div_out))
      osc_cnt_r <= 16'h0000;
    else if ($rose(osc_in))
      osc_cnt_r <= osc_cnt_r + 16'h0001;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      rf_cnt_r <= 16'h0000;
    else if (!chip_enable || $changed(fb_div_out))
      rf_cnt_r <= 16'h0000;
    else if ($rose(rf_input & ~rf_input_complement))
      rf_cnt_r <= rf_cnt_r + 16'h0001;
  end
  // First toggle after a clear comes early: counters restart at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_seen_r <= 1'b0;
      fb_seen_r  <= 1'b0;
    end else if (!chip_enable) begin
      ref_seen_r <= 1'b0;
      fb_seen_r  <= 1'b0;
    end else begin
      if ($changed(ref_div_out)) begin
        ref_seen_r <= 1'b1;
      end
      if ($changed(fb_div_out)) begin
        fb_seen_r <= 1'b1;
      end
    end
  end
  property p_ce_tri; !chip_enable |-> !pump_output_oe; endproperty
  a_ce_tri: assert property (p_ce_tri)
    else $error("pump driven in power down");
  property p_ce_div; !chip_enable |-> !ref_div_out && !fb_div_out; endproperty
  a_ce_div: assert property (p_ce_div)
    else $error("divider output set in power down");
  property p_ce_wake;
    !chip_enable ##1 chip_enable |-> !pump_output_oe [*3];
  endproperty
  a_ce_wake: assert property (p_ce_wake)
    else $error("pump driven straight after power down");
  property p_ref_min;
    chip_enable && ref_seen_r && $changed(ref_div_out) |-> osc_cnt_r >= 2;
  endproperty
  a_ref_min: assert property (p_ref_min)
    else $error("reference period below 2 edges");
  property p_ref_max; osc_cnt_r <= 1023; endproperty
  a_ref_max: assert property (p_ref_max)
    else $error("reference period above 1023 edges");
  property p_fb_min;
    chip_enable && fb_seen_r && $changed(fb_div_out) |-> rf_cnt_r >= 96;
  endproperty
  a_fb_min: assert property (p_fb_min)
    else $error("feedback period below 96 edges");
  property p_fb_max; rf_cnt_r <= 32767; endproperty
  a_fb_max: assert property (p_fb_max)
    else $error("feedback period above 32767 edges");
  property p_oe_tick;
    $rose(pump_output_oe) |-> ref_div_out != $past(ref_div_out, 3)
      || fb_div_out != $past(fb_div_out, 3);
  endproperty
  a_oe_tick: assert property (p_oe_tick)
    else $error("pump driven without a divider tick");
  c_ref: cover property (chip_enable && $changed(ref_div_out));
  c_oe: cover property ($rose(pump_output_oe));
  c_wake: cover property (!chip_enable ##1 chip_enable);
endmodule
bind pdsl_core pdsl_core_properties pdsl_core_properties_i (
  .sys_clk(sys_clk), .rst(rst), .chip_enable(chip_enable),
  .osc_in(osc_in), .rf_input(rf_input),
  .rf_input_complement(rf_input_complement),
  .pump_output_oe(pump_output_oe), .ref_div_out(ref_div_out),
  .fb_div_out(fb_div_out)
);

// ===== tb/pdsl_host.sv
/* Host side of the three-wire programming bus: shifts one 18-bit word
   and raises the load strobe. Assumes sys_clk paces every pin change. */
`timescale 1ns/1ps
module pdsl_host (
  // Pacing clock
  input  wire logic sys_clk,
  // Serial bus
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  // Serial clock idles low between frames
  initial begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // Data held well around each rise, since the pins are filtered
  task automatic send(input logic [17:0] word);
    for (int i = 17; i >= 0; i--) begin
      ser_data = word[i];
      tk(3);
      ser_clk = 1'b1;
      tk(4);
      ser_clk = 1'b0;
      tk(3);
    end
    load_strobe = 1'b1;
    tk(4);
    load_strobe = 1'b0;
    ser_data    = ~word[0]; // Released line shows no stale bit
    tk(4);
  endtask
endmodule

// ===== tb/pdsl_core_test.sv
/* Bench for the divider core: loads both latches through the host model,
   times divider periods and checks pump drive. The checker binds itself. */
`timescale 1ns/1ps
module pdsl_core_test;
  logic sys_clk, rst, chip_enable, osc_in, rf_input, rf_input_complement;
  logic ser_clk, ser_data, load_strobe;
  logic pump_output, pump_output_oe, ref_div_out, fb_div_out;
  int   num_errors = 0;
  int   n_compared = 0;
  int   n;
  // Rows: word as {data, address} beside the divide ratio it should give
  int rows [6][2] = '{'{32'h00005, 2}, '{32'h007ff, 1023},
                      '{32'h00300, 96}, '{32'h01f00, 992},
                      '{32'h01ff8, 1023}, '{32'h00528, 165}};
  pdsl_host pdsl_host_i (.sys_clk(sys_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .load_strobe(load_strobe));
  pdsl_core pdsl_core_i (.sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk),
    .ser_data(ser_data), .load_strobe(load_strobe),
    .chip_enable(chip_enable), .osc_in(osc_in), .rf_input(rf_input),
    .rf_input_complement(rf_input_complement),
    .pump_output(pump_output), .pump_output_oe(pump_output_oe),
    .ref_div_out(ref_div_out), .fb_div_out(fb_div_out));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("counts: %0d errors, %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_int(input int got, input int want);
    n_compared++;
    if (got != want) begin
      num_errors++;
      $display("Error at %0t: %0d edges, want %0d", $time, got, want);
    end
  endtask
  task automatic chk_bit(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: pin %b, want %b", $time, got, want);
    end
  endtask
  // One input edge, held long enough for the pin filter
  task automatic pulse(input logic fb);
    if (fb)
      rf_input = 1'b1;
    else
      osc_in = 1'b1;
    tk(4);
    rf_input = 1'b0;
    osc_in   = 1'b0;
    tk(4);
  endtask
  // Edges until the chosen divider output toggles; bounded
  task automatic measure(input logic fb, output int cnt);
    logic start;
    start = fb ? fb_div_out : ref_div_out;
    cnt = 0;
    while ((fb ? fb_div_out : ref_div_out) === start) begin
      pulse(fb);
      cnt++;
      if (cnt > 1100) begin
        num_errors++;
        print_verdict();
      end
    end
  endtask
  // Skip the partial period, then count one whole period
  task automatic time_ratio(input logic [17:0] w, input int want);
    measure(!w[0], n);
    measure(!w[0], n);
    chk_int(n, want);
  endtask
  initial begin
    rst = 1'b1;
    chip_enable = 1'b1;
    osc_in = 1'b0;
    rf_input = 1'b0;
    rf_input_complement = 1'b0;
    tk(2);
    rst = 1'b0;
    tk(1);
    foreach (rows[i]) begin
      pdsl_host_i.send(18'(rows[i][0]));
      time_ratio(18'(rows[i][0]), rows[i][1]);
    end
    // Pump: three-state word clears, then each polarity, then fb tick
    pdsl_host_i.send(18'h00805);
    chk_bit(pump_output_oe, 1'b0);
    pdsl_host_i.send(18'h01005);
    measure(1'b0, n);
    tk(2);
    chk_bit(pump_output_oe, 1'b1);
    chk_bit(pump_output, 1'b1);
    pdsl_host_i.send(18'h00005);
    chk_bit(pump_output, 1'b0);
    measure(1'b1, n);
    tk(2);
    chk_bit(pump_output_oe, 1'b0);
    measure(1'b0, n);
    tk(2);
    chk_bit(pump_output_oe, 1'b1);
    // Soft power down floats the pump; one edge first so the restarted
    // reference counter still shows a period of two edges
    pulse(1'b0);
    pdsl_host_i.send(18'h00304);
    chk_bit(pump_output_oe, 1'b0);
    pdsl_host_i.send(18'h00300);
    measure(1'b0, n);
    tk(2);
    chk_bit(pump_output_oe, 1'b1);
    // Test mode routes the reference divider output to the pump pin
    pdsl_host_i.send(18'h04805);
    chk_bit(pump_output, ref_div_out);
    measure(1'b0, n);
    tk(2);
    chk_bit(pump_output, ref_div_out);
    chk_bit(pump_output_oe, 1'b1);
    // Power down floats the pump with no clock edge; loading still works
    chip_enable = 1'b0;
    #1;
    chk_bit(pump_output_oe, 1'b0);
    tk(1);
    pdsl_host_i.send(18'h0000b);
    chip_enable = 1'b1;
    tk(2);
    time_ratio(18'h0000b, 5);
    // Reset mid-run brings the reference latch back to a ratio of 2
    rst = 1'b1;
    tk(2);
    rst = 1'b0;
    tk(1);
    time_ratio(18'h00805, 2);
    print_verdict();
  end
endmodule
